// >>> hdl/adcp_control_port.sv
/*
 * Digital side of the 14-bit converter: parallel host port with four
 * registers, result pipeline with offset and format, over-range flag.
 * Assumes host pins, the sample clock pin and the raw core outputs are
 * asynchronous to clk, and that clk is much faster than the sample clock.
 */
// What this block does
// - Address 0 result, 1 gain, 2 offset, 3 control.
// - Write lands in selected register at the strobe's rising edge.
// - Data pins driven only while output enable is low.
// - Register 0 reads latest result; writing bit 0 clears other registers.
// - Gain is the low three bits of register 1, 0 to 7 dB.
// - Offset is signed low byte of register 2, added when enabled.
// - Control bit 7 enables offset addition on every sample.
// - Control bit 12 selects the external reference.
// - Binary codes 0, 8192, 16383; signed codes -8192, 0, 8191.
// - Over-range flag travels with its data word through the pipeline.
// - Result appears 9.5 sample-clock cycles after sampling.
// - Power-down turns analogue off; digital logic keeps running.
// - Control: bit 13 power-down, 12 ref, 11 format, 10-8 test, 7 offset.
// - Format bit one means signed; power-down bit one means powered down.
// - Test codes 000 and 100 normal; others force calibration voltages.
`timescale 1ns/1ps

module adcp_control_port #(
   parameter int DW = adcp_pkg::DATA_W,
   parameter int STAGES = adcp_pkg::LATENCY_STAGES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host port pins
   input wire logic select_n,
   input wire logic write_strobe_n,
   input wire logic bus_drive_n,
   input wire logic reg_select_hi,
   input wire logic reg_select_lo,
   input wire logic [DW-1:0] dataIn,
   output logic [DW-1:0] dataOut,
   output logic dataOe_n,
   // Converter core
   input wire logic sampleClkPin,
   input wire logic [DW-1:0] rawCode,
   input wire logic rawOverRange,
   output logic over_range_flag,
   // Analogue controls
   output logic [2:0] gainSel,
   output logic refExternal,
   output logic powerDown,
   output logic [2:0] testMode,
   output logic testForce
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   localparam int HW = DW + 5;
   logic [HW-1:0] host1_reg, host2_reg, host3_reg;
   logic [DW+1:0] samp1_reg, samp2_reg;
   logic sampClk3_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host1_reg <= '1;
         host2_reg <= '1;
         host3_reg <= '1;
         samp1_reg <= '0;
         samp2_reg <= '0;
         sampClk3_reg <= 1'b0;
      end else begin
         host1_reg <= {select_n, write_strobe_n, bus_drive_n,
                       reg_select_hi, reg_select_lo, dataIn};
         host2_reg <= host1_reg;
         host3_reg <= host2_reg;
         samp1_reg <= {sampleClkPin, rawOverRange, rawCode};
         samp2_reg <= samp1_reg;
         sampClk3_reg <= samp2_reg[DW+1];
      end
   end

   // Data and address are taken from the third stage: that copy was
   // sampled while the strobe was still low, so zero hold time is safe.
   wire strobeNow = host2_reg[DW+3];
   wire strobeOld = host3_reg[DW+3];
   wire selWr = !host3_reg[DW+4];
   wire [1:0] wrAddr = host3_reg[DW+1:DW];
   wire [DW-1:0] wrData = host3_reg[DW-1:0];
   wire selRd = !host2_reg[DW+4];
   wire driveRd = !host2_reg[DW+2];
   wire [1:0] rdAddr = host2_reg[DW+1:DW];
   wire writeEvt = strobeNow && !strobeOld && selWr;
   wire sampRise = samp2_reg[DW+1] && !sampClk3_reg;
   wire outLoad = !samp2_reg[DW+1] && sampClk3_reg;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [2:0] gain_reg, gain_next;
   logic [7:0] offset_reg, offset_next;
   logic [6:0] ctrl_reg, ctrl_next;

   wire softReset = writeEvt && wrAddr == adcp_pkg::ADDR_RESULT
                    && wrData[adcp_pkg::SOFT_RESET_POS];
   wire wrGain = writeEvt && wrAddr == adcp_pkg::ADDR_GAIN;
   wire wrOffset = writeEvt && wrAddr == adcp_pkg::ADDR_OFFSET;
   wire wrCtrl = writeEvt && wrAddr == adcp_pkg::ADDR_CONTROL;

   // Reserved bits are not stored; host writes them as zero anyway.
   assign gain_next = softReset ? adcp_pkg::GAIN_RESET
                    : wrGain ? wrData[adcp_pkg::GAIN_W-1:0] : gain_reg;
   assign offset_next = softReset ? adcp_pkg::OFFSET_RESET
                  : wrOffset ? wrData[adcp_pkg::OFFSET_W-1:0]
                  : offset_reg;
   assign ctrl_next = softReset ? adcp_pkg::CTRL_RESET
                    : wrCtrl ? wrData[DW-1:DW-adcp_pkg::CTRL_W]
                    : ctrl_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_reg <= adcp_pkg::GAIN_RESET;
         offset_reg <= adcp_pkg::OFFSET_RESET;
         ctrl_reg <= adcp_pkg::CTRL_RESET;
      end else begin
         gain_reg <= gain_next;
         offset_reg <= offset_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Full-width views of the control word
   wire [DW-1:0] ctrlWord = {ctrl_reg, 7'h00};
   wire fmtSigned = ctrlWord[adcp_pkg::CTRL_FMT_POS];
   wire applyOffset = ctrlWord[adcp_pkg::CTRL_DCO_POS];
   wire [2:0] tmCode = ctrlWord[adcp_pkg::CTRL_TM_HI:adcp_pkg::CTRL_TM_LO];

   // ---------------------------------------------------------------
   // Result pipeline
   // ---------------------------------------------------------------
   // Capture stage plus nine stepping stages: a code taken at one rise
   // sits in the last stage nine rises later; the output loads on the
   // next falling edge, giving the half cycle.
   logic [DW:0] pipe_reg [STAGES+1];
   logic [DW-1:0] result_reg, result_next;
   logic over_reg;

   function automatic logic [13:0] offsetCode(input logic [13:0] code,
                                              input logic [7:0] off);
      logic signed [15:0] sum;
      sum = $signed({2'b00, code}) + $signed({{8{off[7]}}, off});
      if (sum < 0)
         offsetCode = 14'h0000;
      else if (sum > $signed({1'b0, adcp_pkg::CODE_MAX}))
         offsetCode = adcp_pkg::CODE_MAX[13:0];
      else
         offsetCode = sum[13:0];
   endfunction : offsetCode

   wire [DW-1:0] lastCode = pipe_reg[STAGES][DW-1:0];
   wire [DW-1:0] adjCode = applyOffset ?
                           offsetCode(lastCode, offset_reg) : lastCode;
   // Flipping the top bit maps 0/8192/16383 to -8192/0/8191.
   assign result_next = fmtSigned ?
                        {~adjCode[DW-1], adjCode[DW-2:0]} : adjCode;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i <= STAGES; i++) begin
            pipe_reg[i] <= '0;
         end
      end else if (sampRise) begin
         pipe_reg[0] <= samp2_reg[DW:0];
         for (int i = 1; i <= STAGES; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= adcp_pkg::RESULT_RESET;
         over_reg <= 1'b0;
      end else if (outLoad) begin
         result_reg <= result_next;
         over_reg <= pipe_reg[STAGES][DW];
      end
   end

   // ---------------------------------------------------------------
   // Read path and pin drivers
   // ---------------------------------------------------------------
   logic [DW-1:0] readMux;
   always_comb begin
      unique case (rdAddr)
         adcp_pkg::ADDR_RESULT: readMux = result_reg;
         adcp_pkg::ADDR_GAIN: readMux = {11'h000, gain_reg};
         adcp_pkg::ADDR_OFFSET: readMux = {6'h00, offset_reg};
         adcp_pkg::ADDR_CONTROL: readMux = ctrlWord;
      endcase
   end

   logic [DW-1:0] dataOut_reg;
   logic dataOe_n_reg, over_range_flag_reg, refExternal_reg;
   logic powerDown_reg, testForce_reg;
   logic [2:0] gainSel_reg, testMode_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataOut_reg <= '0;
         dataOe_n_reg <= 1'b1;
         over_range_flag_reg <= 1'b0;
         gainSel_reg <= adcp_pkg::GAIN_RESET;
         refExternal_reg <= 1'b0;
         powerDown_reg <= 1'b0;
         testMode_reg <= 3'h0;
         testForce_reg <= 1'b0;
      end else begin
         dataOut_reg <= readMux;
         dataOe_n_reg <= !(selRd && driveRd);
         over_range_flag_reg <= over_reg;
         gainSel_reg <= gain_reg;
         refExternal_reg <= ctrlWord[adcp_pkg::CTRL_REF_POS];
         // Only analogue is gated; this logic keeps running.
         powerDown_reg <= ctrlWord[adcp_pkg::CTRL_PWD_POS];
         testMode_reg <= tmCode;
         testForce_reg <= tmCode != adcp_pkg::TM_NORMAL_A
                          && tmCode != adcp_pkg::TM_NORMAL_B;
      end
   end

   assign dataOut = dataOut_reg;
   assign dataOe_n = dataOe_n_reg;
   assign over_range_flag = over_range_flag_reg;
   assign gainSel = gainSel_reg;
   assign refExternal = refExternal_reg;
   assign powerDown = powerDown_reg;
   assign testMode = testMode_reg;
   assign testForce = testForce_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_drive_gate;
      !dataOe_n |-> $past(selRd) && $past(driveRd);
   endproperty
   a_drive_gate: assert property (p_drive_gate)
      else $error("data pins driven without select and enable");

   property p_soft_clear;
      softReset |=> gain_reg == 3'h0 && offset_reg == 8'h00
                    && ctrl_reg == 7'h00 ##1 gainSel == 3'h0;
   endproperty
   a_soft_clear: assert property (p_soft_clear)
      else $error("soft reset left a register set");

   property p_gain_write;
      wrGain && !softReset |=> gain_reg == $past(wrData[2:0])
                               ##1 gainSel == $past(wrData[2:0], 2);
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("gain write not captured");

   property p_offset_write;
      wrOffset |=> offset_reg == $past(wrData[7:0]);
   endproperty
   a_offset_write: assert property (p_offset_write)
      else $error("offset write not captured");

   property p_signed_fmt;
      outLoad && fmtSigned && !applyOffset |=>
         result_reg == {~$past(lastCode[13]), $past(lastCode[12:0])};
   endproperty
   a_signed_fmt: assert property (p_signed_fmt)
      else $error("two's complement coding wrong");

   property p_offset_add;
      outLoad && !fmtSigned && applyOffset |=>
         result_reg == offsetCode($past(lastCode), $past(offset_reg));
   endproperty
   a_offset_add: assert property (p_offset_add)
      else $error("offset not added to sample");

   sequence s_flag_load;
      outLoad ##1 1'b1;
   endsequence
   property p_flag_align;
      s_flag_load |-> over_reg == $past(pipe_reg[STAGES][DW])
                      ##1 over_range_flag == $past(over_reg);
   endproperty
   a_flag_align: assert property (p_flag_align)
      else $error("over-range flag out of step with data");

   property p_result_timing;
      $changed(result_reg) |-> $past(outLoad);
   endproperty
   a_result_timing: assert property (p_result_timing)
      else $error("result changed away from output edge");

   property p_ctrl_outputs;
      wrCtrl && !softReset |=> ##1
         powerDown == $past(wrData[13], 2)
         && refExternal == $past(wrData[12], 2);
   endproperty
   a_ctrl_outputs: assert property (p_ctrl_outputs)
      else $error("control outputs do not follow control word");

   property p_test_force;
      testForce |-> testMode != 3'h0 && testMode != 3'h4;
   endproperty
   a_test_force: assert property (p_test_force)
      else $error("test force in a normal test code");

   property p_read_ctrl;
      rdAddr == adcp_pkg::ADDR_CONTROL |=> dataOut == $past(ctrlWord);
   endproperty
   a_read_ctrl: assert property (p_read_ctrl)
      else $error("control readback wrong");
endmodule : adcp_control_port

// >>> hdl/adcp_pkg.sv
/*
 * Constants shared by the converter control port: register map, field
 * positions, reset values, code limits and pipeline depth.
 * Assumes a single 14-bit parallel data bus and two address bits.
 */
package adcp_pkg;
   // ----------------------------------------------------------------
   // Widths and register map
   // ----------------------------------------------------------------
   localparam int DATA_W = 14;
   localparam logic [1:0] ADDR_RESULT = 2'h0;
   localparam logic [1:0] ADDR_GAIN = 2'h1;
   localparam logic [1:0] ADDR_OFFSET = 2'h2;
   localparam logic [1:0] ADDR_CONTROL = 2'h3;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SOFT_RESET_POS = 0;
   localparam int GAIN_W = 3;
   localparam int OFFSET_W = 8;
   localparam int CTRL_PWD_POS = 13;
   localparam int CTRL_REF_POS = 12;
   localparam int CTRL_FMT_POS = 11;
   localparam int CTRL_TM_HI = 10;
   localparam int CTRL_TM_LO = 8;
   localparam int CTRL_DCO_POS = 7;
   localparam int CTRL_W = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] GAIN_RESET = 3'h0;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [13:0] RESULT_RESET = 14'h0000;

   // ----------------------------------------------------------------
   // Codes and timing
   // ----------------------------------------------------------------
   localparam logic [14:0] CODE_MAX = 15'h3fff;
   localparam logic [2:0] TM_NORMAL_A = 3'h0;
   localparam logic [2:0] TM_NORMAL_B = 3'h4;
   localparam int LATENCY_STAGES = 9;
endpackage : adcp_pkg

// >>> bench/adcp_host_model.sv
/*
 * Host processor model for the parallel register port: write and read
 * cycles plus a parked read of the result register for streaming.
 * Assumes the bench resolves the shared data bus from hostBus and the
 * device side, and that clk is the system clock of the block.
 */
`timescale 1ns/1ps

module adcp_host_model (
   // Clock
   input wire logic clk,
   // Port pins
   output logic select_n,
   output logic write_strobe_n,
   output logic bus_drive_n,
   output logic reg_select_hi,
   output logic reg_select_lo,
   output logic [13:0] hostBus,
   // Read side
   input wire logic [13:0] dataOut,
   input wire logic dataOe_n
);
   // ----------------------------------------------------------------
   // Idle pins
   // ----------------------------------------------------------------
   initial begin
      select_n = 1'b1;
      write_strobe_n = 1'b1;
      bus_drive_n = 1'b1;
      {reg_select_hi, reg_select_lo} = 2'h0;
      hostBus = 14'h0000;
   end

   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   task automatic wr(input logic selN, input logic [1:0] a,
                     input logic [13:0] d);
      logic [13:0] keep;
      // Unused bits always sent as zero
      keep = (a == 2'h0) ? 14'h0001 : (a == 2'h1) ? 14'h0007 :
             (a == 2'h2) ? 14'h00ff : 14'h3f80;
      @(negedge clk);
      select_n = selN;
      {reg_select_hi, reg_select_lo} = a;
      hostBus = d & keep;
      write_strobe_n = 1'b0;
      repeat (3) @(negedge clk);
      write_strobe_n = 1'b1;
      repeat (3) @(negedge clk);
      select_n = 1'b1;
      // Released bus shows the inverse, never a stale copy
      hostBus = ~(d & keep);
      repeat (4) @(negedge clk);
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [13:0] d,
                     output logic oeOn, output logic oeOff);
      @(negedge clk);
      select_n = 1'b0;
      {reg_select_hi, reg_select_lo} = a;
      bus_drive_n = 1'b0;
      repeat (5) @(negedge clk);
      d = dataOut;
      oeOn = dataOe_n;
      bus_drive_n = 1'b1;
      select_n = 1'b1;
      repeat (5) @(negedge clk);
      oeOff = dataOe_n;
   endtask : rd

   task automatic park(input logic on);
      @(negedge clk);
      {reg_select_hi, reg_select_lo} = 2'h0;
      select_n = !on;
      bus_drive_n = !on;
   endtask : park
endmodule : adcp_host_model

// >>> bench/adc_parallel_control_port_tb_top.sv
/*
 * Self-checking bench: register access, control decode, soft clear and
 * the sample stream with offset and format, checked through a queue.
 * Assumes the sample clock phases stay 6 clk cycles long.
 */
`timescale 1ns/1ps

module adc_parallel_control_port_tb_top;
   logic clk = 1'b0;
   logic rst_n, select_n, write_strobe_n, bus_drive_n;
   logic reg_select_hi, reg_select_lo, dataOe_n;
   logic [13:0] hostBus, dataIn, dataOut, rawCode, ctrlNow;
   logic sampleClkPin, rawOverRange, over_range_flag;
   logic [2:0] gainSel, testMode;
   logic refExternal, powerDown, testForce;
   logic [7:0] offNow;
   logic [14:0] expQ[$];
   logic [14:0] expWord;
   logic [15:0] lfsr = 16'h0059;
   logic [13:0] cfgCtrl[4] = '{14'h0000, 14'h0880, 14'h0800, 14'h0080};
   logic [7:0] cfgOff[4] = '{8'h00, 8'h85, 8'h40, 8'h7f};
   int err_total = 0;
   int cmp_count = 0;
   int rises = 0;
   int cycles = 0;

   // ----------------------------------------------------------------
   // Clock, bus and instances
   // ----------------------------------------------------------------
   always #12.5 clk = ~clk;
   assign dataIn = (dataOe_n === 1'b0) ? dataOut : hostBus;

   adcp_control_port adcp_control_port_i (.clk(clk), .rst_n(rst_n),
      .select_n(select_n), .write_strobe_n(write_strobe_n),
      .bus_drive_n(bus_drive_n), .reg_select_hi(reg_select_hi),
      .reg_select_lo(reg_select_lo), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe_n(dataOe_n), .sampleClkPin(sampleClkPin),
      .rawCode(rawCode), .rawOverRange(rawOverRange),
      .over_range_flag(over_range_flag), .gainSel(gainSel),
      .refExternal(refExternal), .powerDown(powerDown),
      .testMode(testMode), .testForce(testForce));

   adcp_host_model adcp_host_model_i (.clk(clk), .select_n(select_n),
      .write_strobe_n(write_strobe_n), .bus_drive_n(bus_drive_n),
      .reg_select_hi(reg_select_hi), .reg_select_lo(reg_select_lo),
      .hostBus(hostBus), .dataOut(dataOut), .dataOe_n(dataOe_n));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nextRand

   // Saturate before recoding, as the output stage does
   function automatic logic [13:0] predict(input logic [13:0] raw);
      int v;
      v = int'(raw);
      if (ctrlNow[adcp_pkg::CTRL_DCO_POS]) v += int'($signed(offNow));
      if (v < 0) v = 0;
      if (v > int'(adcp_pkg::CODE_MAX)) v = int'(adcp_pkg::CODE_MAX);
      return ctrlNow[adcp_pkg::CTRL_FMT_POS] ? 14'(v) ^ 14'h2000 : 14'(v);
   endfunction : predict

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic readCheck(input logic [1:0] a, input logic [13:0] exp);
      logic [13:0] d;
      logic on;
      logic off;
      adcp_host_model_i.rd(a, d, on, off);
      check("readData", 16'(d), 16'(exp));
      check("driveOn", 16'(on), 16'h0000);
      check("driveOff", 16'(off), 16'h0001);
   endtask : readCheck

   // First three samples are codes 0, 8192 and 16383
   task automatic stream(input int n);
      rises = 0;
      expQ.delete();
      adcp_host_model_i.park(1'b1);
      repeat (4) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         lfsr = nextRand(lfsr);
         rawCode = (i == 0) ? 14'h0000 : (i == 1) ? 14'h2000 :
                   (i == 2) ? 14'h3fff : lfsr[13:0];
         rawOverRange = lfsr[15];
         sampleClkPin = 1'b1;
         rises++;
         expQ.push_back({rawOverRange, predict(rawCode)});
         repeat (6) @(negedge clk);
         sampleClkPin = 1'b0;
         repeat (6) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      adcp_host_model_i.park(1'b0);
   endtask : stream

   // ----------------------------------------------------------------
   // Result monitor and timeout
   // ----------------------------------------------------------------
   always @(negedge sampleClkPin) begin
      // Sample taken at rise k leaves at the fall after rise k+9
      if (rises >= 10 && expQ.size() > 0) begin
         repeat (8) @(negedge clk);
         expWord = expQ.pop_front();
         check("result", 16'(dataOut), 16'(expWord[13:0]));
         check("overRange", 16'(over_range_flag), 16'(expWord[14]));
      end
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      sampleClkPin = 1'b0;
      rawCode = 14'h0000;
      rawOverRange = 1'b0;
      ctrlNow = 14'h0000;
      offNow = 8'h00;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (int a = 1; a < 4; a++) readCheck(2'(a), 14'h0000);
      for (int g = 0; g < 8; g++) begin
         adcp_host_model_i.wr(1'b0, 2'h1, 14'(g));
         check("gainSel", 16'(gainSel), 16'(g));
         readCheck(2'h1, 14'(g));
      end
      adcp_host_model_i.wr(1'b1, 2'h1, 14'h0002);
      check("gainSel", 16'(gainSel), 16'h0007);
      for (int t = 0; t < 8; t++) begin
         lfsr = nextRand(lfsr);
         ctrlNow = {lfsr[2:0], 3'(t), lfsr[3], 7'h00};
         adcp_host_model_i.wr(1'b0, 2'h3, ctrlNow);
         check("testMode", 16'(testMode), 16'(t));
         check("testForce", 16'(testForce), 16'(t != 0 && t != 4));
         check("powerDown", 16'(powerDown), 16'(ctrlNow[13]));
         check("refExternal", 16'(refExternal), 16'(ctrlNow[12]));
         readCheck(2'h3, ctrlNow);
      end
      for (int c = 0; c < 4; c++) begin
         ctrlNow = cfgCtrl[c];
         offNow = cfgOff[c];
         adcp_host_model_i.wr(1'b0, 2'h2, {6'h00, offNow});
         readCheck(2'h2, {6'h00, offNow});
         adcp_host_model_i.wr(1'b0, 2'h3, ctrlNow);
         stream(14);
      end
      adcp_host_model_i.wr(1'b0, 2'h0, 14'h0001);
      for (int a = 1; a < 4; a++) readCheck(2'(a), 14'h0000);
      check("gainSel", 16'(gainSel), 16'h0000);
      test_done();
   end
endmodule : adc_parallel_control_port_tb_top
